// file: src/margin_slew_pkg.sv
package margin_slew_pkg;
  localparam int          NUM_CH       = 4;
  localparam int          CODE_W       = 12;
  localparam logic [7:0]  ADDR_MHIGH0  = 8'h01;
  localparam logic [7:0]  ADDR_MLOW0   = 8'h02;
  localparam logic [7:0]  ADDR_VOUT0   = 8'h03;
  localparam logic [7:0]  ADDR_FUNC0   = 8'h06;
  localparam logic [7:0]  CH_STRIDE    = 8'h06;
  localparam logic [7:0]  ADDR_COMMON  = 8'h1F;
  localparam logic [7:0]  ADDR_TRIGGER = 8'h20;
  localparam logic [7:0]  ADDR_PINCFG  = 8'h24;
  localparam logic [7:0]  ADDR_OPCMD0  = 8'h30;
  localparam logic [15:0] SAVE_NVM_VAL = 16'h0002;
  localparam logic [7:0]  OP_OFF       = 8'h00;
  localparam logic [7:0]  OP_ON        = 8'h80;
  localparam logic [7:0]  OP_MHIGH     = 8'hA4;
  localparam logic [7:0]  OP_MLOW      = 8'h94;
  // pin setup fields
  localparam int          PIN_EN_BIT   = 0;
  localparam int          PIN_SDO_BIT  = 1;
  localparam int          PIN_FN_LSB   = 1;
  localparam int          PIN_SEL_LSB  = 5;
  localparam logic [3:0]  FN_MARGIN    = 4'h2;
  localparam logic [3:0]  FN_POWER     = 4'h4;
  // function setup fields
  localparam int          STEP_LSB     = 4;
  localparam int          RATE_LSB     = 0;
  // common setup: 2 power bits per channel, 2'b00 = up
  localparam int          PD_LSB       = 1;
  localparam logic [1:0]  PD_HIZ       = 2'b11;
  localparam int          TIMEOUT_BIT  = 0;
  localparam logic [15:0] RST_PINCFG   = 16'h0000;
  localparam logic [15:0] RST_COMMON   = 16'h1FFE;
  localparam logic [15:0] RST_FUNC     = 16'h0000;
  localparam int          BASE_TICK    = 100;
  localparam int          I2C_TO_NS    = 30000;
  localparam int          CLK_NS       = 10;
  localparam int          I2C_TO_CYC   = I2C_TO_NS / CLK_NS;
  typedef enum logic [1:0] {PROTO_I2C, PROTO_SPI, PROTO_PMBUS} proto_t;
  typedef struct packed {
    logic        valid;
    logic [7:0]  addr;
    logic [15:0] data;
  } reg_wr_t;
endpackage

// file: src/slew_channel.sv
`timescale 1ns/1ps
module slew_channel
  import margin_slew_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              tick_i,
  input  wire logic              load_i,
  input  wire logic [CODE_W-1:0] load_code_i,
  input  wire logic              go_i,
  input  wire logic [CODE_W-1:0] target_i,
  input  wire logic [3:0]        step_sel_i,
  input  wire logic [3:0]        rate_sel_i,
  output logic      [CODE_W-1:0] code_o
);
  logic [CODE_W-1:0] tgt_q;
  logic [CODE_W:0]   step;
  logic [19:0]       div_q;
  logic              slewing_q;

  assign step = (CODE_W+1)'(1) << step_sel_i[2:0];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      code_o    <= '0;
      tgt_q     <= '0;
      div_q     <= '0;
      slewing_q <= 1'b0;
    end else if (load_i) begin
      code_o    <= load_code_i;
      slewing_q <= 1'b0;
    end else if (go_i) begin
      tgt_q     <= target_i;
      div_q     <= '0;
      slewing_q <= 1'b1;
    end else if (slewing_q && tick_i) begin
      if (div_q < 20'(rate_sel_i)) begin
        div_q <= div_q + 20'd1;
      end else begin
        // one step per interval, clamp at target
        div_q <= '0;
        if (code_o < tgt_q) begin
          code_o <= ({1'b0, tgt_q} - {1'b0, code_o} <= step) ? tgt_q :
                    code_o + step[CODE_W-1:0];
        end else if (code_o > tgt_q) begin
          code_o <= ({1'b0, code_o} - {1'b0, tgt_q} <= step) ? tgt_q :
                    code_o - step[CODE_W-1:0];
        end else begin
          slewing_q <= 1'b0;
        end
      end
    end
  end
endmodule

// file: src/margin_slew_ctrl.sv
`timescale 1ns/1ps
module margin_slew_ctrl
  import margin_slew_pkg::*;
#(
  parameter int TIMEOUT_CYC = I2C_TO_CYC
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     spi_sel_pin_i,
  input  wire logic                     pmbus_pin_i,
  input  wire logic                     gp_pin_i,
  input  wire logic                     wr_valid_i,
  input  wire logic [7:0]               wr_addr_i,
  input  wire logic [15:0]              wr_data_i,
  input  wire logic                     rd_req_i,
  input  wire logic [7:0]               rd_addr_i,
  input  wire logic                     bus_active_i,
  input  wire logic                     nvm_done_i,
  input  wire logic [NUM_CH*16-1:0]     nvm_code_i,
  output logic [1:0]                    proto_o,
  output logic                          proto_locked_o,
  output logic                          bus_timeout_o,
  output logic [15:0]                   rd_data_o,
  output logic                          rd_valid_o,
  output logic                          sdo_en_o,
  output logic                          nvm_save_o,
  output logic [NUM_CH*16-1:0]          code_o,
  output logic [NUM_CH-1:0]             out_on_o,
  output logic [NUM_CH*2-1:0]           pd_mode_o
);
  reg_wr_t                   wr;
  logic [15:0]               pincfg_q;
  logic [15:0]               common_q;
  logic [15:0]               mhigh_q [NUM_CH];
  logic [15:0]               mlow_q  [NUM_CH];
  logic [15:0]               vout_q  [NUM_CH];
  logic [15:0]               func_q  [NUM_CH];
  logic [1:0]                gp_sync_q;
  logic                      gp_prev_q;
  logic [1:0]                spi_sync_q;
  logic [1:0]                pm_sync_q;
  logic [1:0]                lock_cnt_q;
  logic [6:0]                tick_cnt_q;
  logic                      tick;
  logic [31:0]               to_cnt_q;
  logic                      gp_rise;
  logic                      gp_fall;
  logic [NUM_CH-1:0]         ch_sel;
  logic [NUM_CH-1:0]         go;
  logic [NUM_CH-1:0]         load;
  logic [CODE_W-1:0]         target [NUM_CH];
  logic [CODE_W-1:0]         load_code [NUM_CH];
  logic [CODE_W-1:0]         ch_code [NUM_CH];
  logic [NUM_CH-1:0]         pd_q;
  logic                      pin_in;
  logic [3:0]                pin_fn;

  assign wr = '{valid: wr_valid_i, addr: wr_addr_i, data: wr_data_i};

  // pins from outside the clock domain
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gp_sync_q  <= '0;
      spi_sync_q <= '0;
      pm_sync_q  <= '0;
      gp_prev_q  <= 1'b0;
    end else begin
      gp_sync_q  <= {gp_sync_q[0], gp_pin_i};
      spi_sync_q <= {spi_sync_q[0], spi_sel_pin_i};
      pm_sync_q  <= {pm_sync_q[0], pmbus_pin_i};
      gp_prev_q  <= gp_sync_q[1];
    end
  end

  // detect once, then hold until rst_n_i is asserted
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_cnt_q     <= '0;
      proto_o        <= PROTO_I2C;
      proto_locked_o <= 1'b0;
    end else if (!proto_locked_o) begin
      if (lock_cnt_q != 2'd3) begin
        lock_cnt_q <= lock_cnt_q + 2'd1;
      end else begin
        proto_locked_o <= 1'b1;
        proto_o        <= spi_sync_q[1] ? PROTO_SPI :
                          pm_sync_q[1]  ? PROTO_PMBUS : PROTO_I2C;
      end
    end
  end

  // i2c and pmbus stall timeout (not spi), only when software enables it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      to_cnt_q      <= '0;
      bus_timeout_o <= 1'b0;
    end else if (proto_o == PROTO_SPI || !common_q[TIMEOUT_BIT] || !bus_active_i) begin
      to_cnt_q      <= '0;
      bus_timeout_o <= 1'b0;
    end else if (to_cnt_q == 32'(TIMEOUT_CYC - 1)) begin
      bus_timeout_o <= 1'b1;
    end else begin
      to_cnt_q <= to_cnt_q + 32'd1;
    end
  end

  // register writes: address, msb, lsb already assembled
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pincfg_q <= RST_PINCFG;
      common_q <= RST_COMMON;
      for (int i = 0; i < NUM_CH; i++) begin
        mhigh_q[i] <= '0;
        mlow_q[i]  <= '0;
        vout_q[i]  <= '0;
        func_q[i]  <= RST_FUNC;
      end
    end else if (wr.valid && !bus_timeout_o) begin
      if (wr.addr == ADDR_PINCFG) begin
        pincfg_q <= wr.data;
      end
      if (wr.addr == ADDR_COMMON) begin
        common_q <= wr.data;
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (wr.addr == ADDR_MHIGH0 + 8'(i) * CH_STRIDE) begin
          mhigh_q[i] <= wr.data;
        end
        if (wr.addr == ADDR_MLOW0 + 8'(i) * CH_STRIDE) begin
          mlow_q[i] <= wr.data;
        end
        if (wr.addr == ADDR_VOUT0 + 8'(i) * CH_STRIDE) begin
          vout_q[i] <= wr.data;
        end
        if (wr.addr == ADDR_FUNC0 + 8'(i) * CH_STRIDE) begin
          func_q[i] <= wr.data;
        end
      end
    end
  end

  // nvm save strobe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nvm_save_o <= 1'b0;
    end else begin
      nvm_save_o <= wr.valid && !bus_timeout_o && wr.addr == ADDR_TRIGGER &&
                    wr.data == SAVE_NVM_VAL;
    end
  end

  // readback; spi needs the pin as data-out
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o  <= '0;
      rd_valid_o <= 1'b0;
      sdo_en_o   <= 1'b0;
    end else begin
      sdo_en_o   <= proto_o == PROTO_SPI && pincfg_q[PIN_SDO_BIT] &&
                    !pincfg_q[PIN_EN_BIT];
      rd_valid_o <= rd_req_i && (proto_o != PROTO_SPI ||
                    (pincfg_q[PIN_SDO_BIT] && !pincfg_q[PIN_EN_BIT]));
      rd_data_o  <= '0;
      if (rd_addr_i == ADDR_PINCFG) begin
        rd_data_o <= pincfg_q;
      end
      if (rd_addr_i == ADDR_COMMON) begin
        rd_data_o <= common_q;
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (rd_addr_i == ADDR_MHIGH0 + 8'(i) * CH_STRIDE) begin
          rd_data_o <= mhigh_q[i];
        end
        if (rd_addr_i == ADDR_MLOW0 + 8'(i) * CH_STRIDE) begin
          rd_data_o <= mlow_q[i];
        end
        if (rd_addr_i == ADDR_VOUT0 + 8'(i) * CH_STRIDE) begin
          rd_data_o <= vout_q[i];
        end
        if (rd_addr_i == ADDR_FUNC0 + 8'(i) * CH_STRIDE) begin
          rd_data_o <= func_q[i];
        end
      end
    end
  end

  // slew time base
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= (tick_cnt_q == 7'(BASE_TICK - 1)) ? 7'd0 : tick_cnt_q + 7'd1;
    end
  end
  assign tick = tick_cnt_q == 7'(BASE_TICK - 1);

  assign pin_in  = pincfg_q[PIN_EN_BIT] && proto_o != PROTO_SPI;
  assign pin_fn  = pincfg_q[PIN_FN_LSB +: 4];
  assign ch_sel  = pincfg_q[PIN_SEL_LSB +: NUM_CH];
  assign gp_rise = pin_in && gp_sync_q[1] && !gp_prev_q;
  assign gp_fall = pin_in && !gp_sync_q[1] && gp_prev_q;

  // margin triggers from pin or operation command
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      go[i]        = 1'b0;
      target[i]    = mlow_q[i][15 -: CODE_W];
      load[i]      = nvm_done_i;
      load_code[i] = nvm_code_i[i*16+15 -: CODE_W];
      if (ch_sel[i] && pin_fn == FN_MARGIN && (gp_rise || gp_fall)) begin
        go[i]     = 1'b1;
        target[i] = gp_rise ? mhigh_q[i][15 -: CODE_W] : mlow_q[i][15 -: CODE_W];
      end
      if (wr.valid && !bus_timeout_o && wr.addr == ADDR_OPCMD0 + 8'(i)) begin
        if (wr.data[15:8] == OP_MHIGH) begin
          go[i]     = 1'b1;
          target[i] = mhigh_q[i][15 -: CODE_W];
        end else if (wr.data[15:8] == OP_MLOW) begin
          go[i] = 1'b1;
        end
      end
    end
  end

  // power toggles act at once, no slew
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pd_q <= '1;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (ch_sel[i] && pin_fn == FN_POWER && gp_rise) begin
          pd_q[i] <= 1'b0;
        end else if (ch_sel[i] && pin_fn == FN_POWER && gp_fall) begin
          pd_q[i] <= 1'b1;
        end else if (wr.valid && !bus_timeout_o && wr.addr == ADDR_OPCMD0 + 8'(i)) begin
          if (wr.data[15:8] == OP_ON) begin
            pd_q[i] <= 1'b0;
          end else if (wr.data[15:8] == OP_OFF) begin
            pd_q[i] <= 1'b1;
          end
        end else if (wr.valid && !bus_timeout_o && wr.addr == ADDR_COMMON) begin
          pd_q[i] <= wr.data[PD_LSB+2*i +: 2] != 2'b00;
        end
      end
    end
  end

  // per-channel slew engines step the codes toward the targets
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    slew_channel u_slew (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .tick_i      (tick),
      .load_i      (load[g]),
      .load_code_i (load_code[g]),
      .go_i        (go[g]),
      .target_i    (target[g]),
      .step_sel_i  (func_q[g][STEP_LSB +: 4]),
      .rate_sel_i  (func_q[g][RATE_LSB +: 4]),
      .code_o      (ch_code[g])
    );
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      code_o    <= '0;
      out_on_o  <= '0;
      pd_mode_o <= {NUM_CH{PD_HIZ}};
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        code_o[i*16 +: 16] <= {ch_code[i], 4'h0};
        out_on_o[i]        <= !pd_q[i];
        // default hi-z unless common setup picks another mode
        pd_mode_o[i*2 +: 2] <= pd_q[i] ? (common_q[PD_LSB+2*i +: 2] == 2'b00 ?
                               PD_HIZ : common_q[PD_LSB+2*i +: 2]) : 2'b00;
      end
    end
  end
endmodule

// file: tb/margin_slew_checker_assertions.sv
`timescale 1ns/1ps
module margin_slew_checker
  import margin_slew_pkg::*;
#(
  parameter int TIMEOUT_CYC = I2C_TO_CYC
) (
  input wire logic                 clk_i,
  input wire logic                 rst_n_i,
  input wire logic                 wr_valid_i,
  input wire logic [7:0]           wr_addr_i,
  input wire logic [15:0]          wr_data_i,
  input wire logic                 rd_req_i,
  input wire logic                 bus_active_i,
  input wire logic                 nvm_done_i,
  input wire logic [NUM_CH*16-1:0] nvm_code_i,
  input wire logic [1:0]           proto_o,
  input wire logic                 proto_locked_o,
  input wire logic                 bus_timeout_o,
  input wire logic                 rd_valid_o,
  input wire logic                 sdo_en_o,
  input wire logic                 nvm_save_o,
  input wire logic [NUM_CH*16-1:0] code_o,
  input wire logic [NUM_CH-1:0]    out_on_o,
  input wire logic [NUM_CH*2-1:0]  pd_mode_o
);
  logic [2:0]  up_q;
  logic [2:0]  nd_q;
  logic [7:0]  gap_q;
  logic [9:0]  act_q;
  logic [15:0] last_q;
  logic        to_en_q;
  logic        chg;
  assign chg = code_o[15:0] != last_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) up_q <= '0;
    else if (up_q != 3'h7) up_q <= up_q + 3'h1;
  end
  // nvm loads jump the code, so they set the gap count to its 8'hFF ceiling
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nd_q   <= '0;
      last_q <= '0;
      gap_q  <= 8'hFF;
    end else begin
      nd_q   <= {nd_q[1:0], nvm_done_i};
      last_q <= code_o[15:0];
      if (chg) gap_q <= (|nd_q) ? 8'hFF : 8'h00;
      else if (gap_q != 8'hFF) gap_q <= gap_q + 8'h01;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) act_q <= '0;
    else if (!bus_active_i) act_q <= '0;
    else if (act_q != 10'h3FF) act_q <= act_q + 10'h001;
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) to_en_q <= RST_COMMON[TIMEOUT_BIT];
    else if (wr_valid_i && wr_addr_i == ADDR_COMMON && !bus_timeout_o)
      to_en_q <= wr_data_i[TIMEOUT_BIT];
  end
  sequence s_save;
    wr_valid_i && wr_addr_i == ADDR_TRIGGER && wr_data_i == SAVE_NVM_VAL && !bus_timeout_o;
  endsequence
  sequence s_on0;
    wr_valid_i && wr_addr_i == ADDR_OPCMD0 && wr_data_i[15:8] == OP_ON && !bus_timeout_o;
  endsequence
  sequence s_off2;
    !out_on_o[0] ##1 !out_on_o[0];
  endsequence
  property p_lock_hold;
    proto_locked_o |=> proto_locked_o && $stable(proto_o);
  endproperty
  property p_lock_time;
    up_q == 3'h6 |-> proto_locked_o;
  endproperty
  property p_save;
    s_save |=> nvm_save_o;
  endproperty
  property p_save_cause;
    nvm_save_o |-> $past(wr_valid_i) && $past(wr_addr_i) == ADDR_TRIGGER;
  endproperty
  property p_rd_refuse;
    rd_req_i && proto_o == PROTO_SPI && !sdo_en_o |=> !rd_valid_o;
  endproperty
  property p_off_mode;
    s_off2 |-> $past(pd_mode_o[1:0]) != 2'b00;
  endproperty
  property p_op_on;
    s_on0 |-> ##2 out_on_o[0];
  endproperty
  property p_nvm_load;
    nvm_done_i |-> ##[1:2] code_o[15:4] == nvm_code_i[15:4];
  endproperty
  property p_slew_gap;
    chg && nd_q == 3'b000 |-> gap_q >= 8'd90;
  endproperty
  property p_timeout;
    proto_o == PROTO_I2C && to_en_q && act_q == TIMEOUT_CYC + 4 |-> bus_timeout_o;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("protocol moved after lock");
  a_lock_time: assert property (p_lock_time) else $error("protocol not locked");
  a_save: assert property (p_save) else $error("save pulse missing");
  a_save_cause: assert property (p_save_cause) else $error("save pulse without trigger");
  a_rd_refuse: assert property (p_rd_refuse) else $error("read answered without data out");
  a_off_mode: assert property (p_off_mode) else $error("off channel not in power-down");
  a_op_on: assert property (p_op_on) else $error("operation on ignored");
  a_nvm_load: assert property (p_nvm_load) else $error("stored code not loaded");
  a_slew_gap: assert property (p_slew_gap) else $error("code stepped faster than rate");
  a_timeout: assert property (p_timeout) else $error("stall not timed out");
endmodule

bind margin_slew_ctrl margin_slew_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .wr_valid_i(wr_valid_i), .wr_addr_i(wr_addr_i),
  .wr_data_i(wr_data_i), .rd_req_i(rd_req_i), .bus_active_i(bus_active_i),
  .nvm_done_i(nvm_done_i), .nvm_code_i(nvm_code_i), .proto_o(proto_o),
  .proto_locked_o(proto_locked_o), .bus_timeout_o(bus_timeout_o), .rd_valid_o(rd_valid_o),
  .sdo_en_o(sdo_en_o), .nvm_save_o(nvm_save_o), .code_o(code_o), .out_on_o(out_on_o),
  .pd_mode_o(pd_mode_o));

// file: tb/host_model.sv
`timescale 1ns/1ps
module host_model #(
  parameter int RD_GAP = 4
) (
  input  wire logic        clk_i,
  output logic             wr_valid_o,
  output logic [7:0]       wr_addr_o,
  output logic [15:0]      wr_data_o,
  output logic             rd_req_o,
  output logic [7:0]       rd_addr_o,
  output logic             bus_active_o
);
  initial begin
    wr_valid_o   = 1'b0;
    wr_addr_o    = 8'h00;
    wr_data_o    = 16'h0000;
    rd_req_o     = 1'b0;
    rd_addr_o    = 8'h00;
    bus_active_o = 1'b0;
  end
  // address, msb byte and lsb byte driven together for one cycle; released lines show the inverse
  task automatic wr(input logic [7:0] a, input logic [7:0] msb, input logic [7:0] lsb);
    @(posedge clk_i);
    #1;
    wr_valid_o   = 1'b1;
    wr_addr_o    = a;
    wr_data_o    = {msb, lsb};
    bus_active_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_valid_o   = 1'b0;
    wr_addr_o    = ~a;
    wr_data_o    = ~{msb, lsb};
    bus_active_o = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    #1;
    rd_req_o     = 1'b1;
    rd_addr_o    = a;
    bus_active_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_req_o  = 1'b0;
    rd_addr_o = ~a;
    // after the request the bus stays busy for RD_GAP more cycles
    repeat (RD_GAP) @(posedge clk_i);
    #1;
    bus_active_o = 1'b0;
  endtask
  // a transfer that hangs mid-way
  task automatic stall(input int n);
    @(posedge clk_i);
    #1;
    bus_active_o = 1'b1;
    repeat (n) @(posedge clk_i);
    #1;
    bus_active_o = 1'b0;
  endtask
endmodule

// file: tb/gpi_margin_slew_control_test.sv
`timescale 1ns/1ps
module gpi_margin_slew_control_test
  import margin_slew_pkg::*;
;
  logic        clk_i, rst_n_i, spi_sel, pmbus_sel, gp_pin, nvm_done;
  logic [63:0] nvm_code, code;
  logic        wr_valid, rd_req, bus_active, locked, tmo, rd_valid, sdo_en, nvm_save;
  logic [7:0]  wr_addr, rd_addr, pd_mode;
  logic [15:0] wr_data, rd_data, r;
  logic [1:0]  proto;
  logic [3:0]  out_on;
  logic [15:0] exp_q[$];
  int          num_errors, total_checks, saves;
  margin_slew_ctrl #(.TIMEOUT_CYC(20)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .spi_sel_pin_i(spi_sel), .pmbus_pin_i(pmbus_sel), .gp_pin_i(gp_pin),
    .wr_valid_i(wr_valid), .wr_addr_i(wr_addr), .wr_data_i(wr_data), .rd_req_i(rd_req),
    .rd_addr_i(rd_addr), .bus_active_i(bus_active), .nvm_done_i(nvm_done),
    .nvm_code_i(nvm_code), .proto_o(proto), .proto_locked_o(locked), .bus_timeout_o(tmo),
    .rd_data_o(rd_data), .rd_valid_o(rd_valid), .sdo_en_o(sdo_en), .nvm_save_o(nvm_save),
    .code_o(code), .out_on_o(out_on), .pd_mode_o(pd_mode));
  host_model host (.clk_i(clk_i), .wr_valid_o(wr_valid), .wr_addr_o(wr_addr),
    .wr_data_o(wr_data), .rd_req_o(rd_req), .rd_addr_o(rd_addr), .bus_active_o(bus_active));
  always #5 clk_i = ~clk_i;
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    host.wr(a, d[15:8], d[7:0]);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask
  task automatic boot(input logic spi);
    rst_n_i = 1'b0;
    spi_sel = spi;
    pmbus_sel = 1'b0;
    cyc(5);
    rst_n_i = 1'b1;
  endtask
  task automatic load(input logic [15:0] v);
    nvm_code = {4{v}};
    nvm_done = 1'b1;
    cyc(1);
    nvm_done = 1'b0;
    cyc(3);
  endtask
  // bounded wait on the channel 0 code
  task automatic wait_code(input logic [15:0] e, input int lim);
    int i;
    for (i = 0; i < lim && code[15:0] !== e; i++) cyc(1);
    check(code[15:0], e);
    if (i == lim) wrap_up();
  endtask
  always @(posedge clk_i) begin
    if (nvm_save === 1'b1) saves++;
    if (rd_valid === 1'b1) begin
      if (exp_q.size() > 0) check(rd_data, exp_q.pop_front());
      else check(1'b1, 1'b0);
    end
  end
  initial begin
    clk_i = 1'b0;
    gp_pin = 1'b0;
    nvm_done = 1'b0;
    nvm_code = '0;
    void'($urandom(32'hEF7B));
    boot(1'b1);
    check(pd_mode, 8'hFF);
    check(out_on, 4'h0);
    cyc(6);
    check(locked, 1'b1);
    check(proto, PROTO_SPI);
    check(sdo_en, 1'b0);
    spi_sel = 1'b0;
    pmbus_sel = 1'b1;
    cyc(8);
    check(proto, PROTO_SPI);
    host.rd(ADDR_MHIGH0);
    cyc(3);
    wr(ADDR_PINCFG, 16'h0002);
    cyc(2);
    check(sdo_en, 1'b1);
    r = 16'($urandom) & 16'hFFF0;
    wr(ADDR_MHIGH0, r);
    rd(ADDR_MHIGH0, r);
    wr(ADDR_TRIGGER, SAVE_NVM_VAL);
    wr(ADDR_TRIGGER, 16'h0004);
    cyc(3);
    check(saves, 1);
    r = 16'($urandom);
    load(r);
    check(code[15:4], r[15:4]);
    wr(ADDR_COMMON, 16'h0006);
    cyc(3);
    check({out_on, pd_mode[1:0]}, {4'hE, PD_HIZ});
    wr(ADDR_COMMON, 16'h0000);
    cyc(3);
    check({out_on, pd_mode}, 12'hF00);
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_OPCMD0, {k[0] ? OP_ON : OP_OFF, 8'h00});
      cyc(3);
      check(out_on[0], k[0]);
    end
    // pin input is held off under spi, so rerun from reset on i2c
    boot(1'b0);
    cyc(6);
    check(proto, PROTO_I2C);
    wr(ADDR_COMMON, RST_COMMON);
    wr(ADDR_PINCFG, {7'h0, 4'b0101, FN_POWER, 1'b0});
    gp_pin = 1'b1;
    cyc(8);
    check(out_on, 4'h0);
    gp_pin = 1'b0;
    cyc(4);
    wr(ADDR_PINCFG, {7'h0, 4'b0101, FN_POWER, 1'b1});
    gp_pin = 1'b1;
    cyc(6);
    check(out_on, 4'h5);
    gp_pin = 1'b0;
    cyc(6);
    check(out_on, 4'h0);
    load(16'h0000);
    wr(ADDR_FUNC0, 16'h0020);
    wr(ADDR_MHIGH0, 16'h0400);
    wr(ADDR_MLOW0, 16'h0000);
    wr(ADDR_PINCFG, {7'h0, 4'b0001, FN_MARGIN, 1'b1});
    gp_pin = 1'b1;
    cyc(150);
    check(code[15:0] !== 16'h0000 && code[15:0] !== 16'h0400, 1'b1);
    wait_code(16'h0400, 2500);
    check(code[31:16], 16'h0000);
    wr(ADDR_MHIGH0, 16'h0800);
    cyc(300);
    check(code[15:0], 16'h0400);
    gp_pin = 1'b0;
    wait_code(16'h0000, 2500);
    boot(1'b0);
    cyc(6);
    check(proto, PROTO_I2C);
    wr(ADDR_COMMON, RST_COMMON | 16'h0001);
    host.stall(30);
    check(tmo, 1'b1);
    wrap_up();
  end
  initial begin
    #900000;
    num_errors++;
    wrap_up();
  end
endmodule
